// >>> hbridge_pkg.sv
// package for the h-bridge output and fault control block
// assumes a single 40 MHz ref_clk domain; analog comparators arrive as synchronous levels
package hbridge_pkg;

    localparam int CLK_MHZ = 40;
    localparam int BLANK_US = 32;
    localparam int BLANK_WARM_FACTOR = 8;
    localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
    localparam int BLANK_WARM_CYC = BLANK_CYC * BLANK_WARM_FACTOR;
    localparam int OL_STAGE_US = 16;
    localparam int OL_STAGE_CYC = OL_STAGE_US * CLK_MHZ;
    localparam int CNT_W = 16;

    localparam logic [2:0] EDGE_RATE_RESET = 3'h4;
    localparam logic [2:0] EDGE_RATE_BYPASS = 3'h0;
    localparam logic [15:0] SPI_ZERO_WORD = 16'h0000;

    // gate drive of one leg
    typedef struct packed {
        logic hs;
        logic ls;
    } leg_drive_t;

    // latched and live faults
    typedef struct packed {
        logic overheat_fault;
        logic short_ground_a;
        logic short_ground_b;
        logic short_supply_a;
        logic short_supply_b;
        logic supply_high_fault;
        logic supply_low_fault;
    } fault_set_t;

    typedef enum logic [3:0] {
        CL_IDLE = 4'h1,
        CL_BLANK = 4'h2,
        CL_DECAY = 4'h4,
        CL_HOLD = 4'h8
    } climit_state_t;

    typedef enum logic [2:0] {
        OL_IDLE = 3'h1,
        OL_DISCHARGE = 3'h2,
        OL_PULLUP = 3'h4
    } olstby_state_t;

endpackage

// >>> leg_drive.sv
// one half-bridge leg: converts a level command into non-overlapping gate drive
// assumes drive_high and drive_low are synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module leg_drive #(
    parameter int DEAD_CYC = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // command
    input wire logic drive_high,
    input wire logic drive_low,
    // gates
    output hbridge_pkg::leg_drive_t gate
);
    initial begin
        if (DEAD_CYC < 1) $error("leg_drive: DEAD_CYC must be at least 1");
    end

    logic [7:0] dead_r;
    logic want_hs;
    logic want_ls;

    assign want_hs = drive_high && !drive_low;
    assign want_ls = drive_low && !drive_high;

    // dead time after any turn-off so both switches are never on together
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            gate <= '0;
            dead_r <= 8'h00;
        end else if ((gate.hs && !want_hs) || (gate.ls && !want_ls)) begin
            gate <= '0;
            dead_r <= 8'(DEAD_CYC);
        end else if (dead_r != 8'h00) begin
            dead_r <= dead_r - 8'h01;
        end else begin
            gate.hs <= want_hs && !gate.ls;
            gate.ls <= want_ls && !gate.hs;
        end
    end
endmodule
`default_nettype wire

// >>> hbridge_ctrl.sv
// h-bridge / half-bridge output, fault arbitration, current limit and open-load control
// assumes comparator inputs are already filtered and synchronous to the 40 MHz ref_clk
// Notes on behaviour
// - no io supply, serial output word is zero
// - half-bridge pin mode: inputs drive outputs directly
// - spi mode: virtual inputs replace physical ones
// - h-bridge pin mode: direction and pwm inputs
// - active recirculation, never cross conduction
// - half-bridge disables limit, overvoltage, open load
// - shorts per leg in half, whole bridge
// - gate, shutoff, software bit disable outputs
// - h-bridge fault priority order
// - half-bridge fault priority order
// - edge rate selectable, code bypasses slew
// - four-step threshold, exceed starts limit, flags
// - blanking, then high-side recirculation twice decay
// - warm die multiplies blanking by eight
// - no turn-on above limit, off resets
// - standby open load only in standby h-bridge
// - test starts on wake or request rise
// - stage one: both low sides, shorts protected
// - stage two: pull-up on a, flag if high
// - after latching, outputs return to commanded
// - active open load only when h-bridge switching
// - no overshoot between low-off and low-on flags
// - result held until next window ends
// - no toggling, no open-load report
// - short current shuts off, needs fault clear
// - edge rate resets to code four
`timescale 1ns/1ps
`default_nettype none
module hbridge_ctrl #(
    parameter int BLANK_CYC = hbridge_pkg::BLANK_CYC,
    parameter int BLANK_WARM_CYC = hbridge_pkg::BLANK_WARM_CYC,
    parameter int OL_STAGE_CYC = hbridge_pkg::OL_STAGE_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // configuration from the spi register file
    input wire logic half_bridge_mode,
    input wire logic spi_control,
    input wire logic virtual_input_one,
    input wire logic virtual_input_two,
    input wire logic software_output_gate,
    input wire logic load_check_request,
    input wire logic [1:0] current_threshold,
    input wire logic [2:0] edge_rate_wr_data,
    input wire logic edge_rate_wr,
    input wire logic fault_clear,
    input wire logic standby,
    // pins
    input wire logic phys_input_one,
    input wire logic phys_input_two,
    input wire logic active_gate_input,
    input wire logic shutoff_input,
    input wire logic io_supply_pin,
    input wire logic [15:0] spi_word_in,
    // analog comparators
    input wire logic over_limit,
    input wire logic die_warm,
    input wire hbridge_pkg::fault_set_t fault_live,
    input wire logic overshoot_seen,
    input wire logic out_a_above_ol,
    // outputs
    output hbridge_pkg::leg_drive_t gate_a,
    output hbridge_pkg::leg_drive_t gate_b,
    output logic pullup_a_on,
    output logic [2:0] edge_rate_select,
    output logic slew_bypass,
    output logic [1:0] limit_level,
    output logic [15:0] spi_word_out,
    output hbridge_pkg::fault_set_t fault_flags,
    output logic overcurrent_flag,
    output logic open_load_flag
);
    initial begin
        if (BLANK_CYC < 1 || BLANK_WARM_CYC < BLANK_CYC || BLANK_WARM_CYC >= (1 << hbridge_pkg::CNT_W))
            $error("hbridge_ctrl: blanking counts out of range");
        if (OL_STAGE_CYC < 1 || OL_STAGE_CYC >= (1 << hbridge_pkg::CNT_W))
            $error("hbridge_ctrl: open-load stage count out of range");
    end

    logic in_one;
    logic in_two;
    logic want_a_hi;
    logic want_a_lo;
    logic want_b_hi;
    logic want_b_lo;
    logic short_a;
    logic short_b;
    logic kill_a;
    logic kill_b;
    logic brake_hs;
    logic both_low;
    logic a_hi;
    logic a_lo;
    logic b_hi;
    logic b_lo;
    logic in_off_edge;
    logic prev_a_r;
    logic prev_b_r;
    logic standby_r;
    logic check_r;
    logic ol_start;
    logic ls_off_win_r;
    logic seen_r;
    logic ls_off;
    hbridge_pkg::climit_state_t cl_r;
    hbridge_pkg::olstby_state_t ol_r;
    logic [hbridge_pkg::CNT_W-1:0] cl_cnt_r;
    logic [hbridge_pkg::CNT_W-1:0] decay_r;
    logic [hbridge_pkg::CNT_W-1:0] ol_cnt_r;

    // input source and mode mapping
    assign in_one = spi_control ? virtual_input_one : phys_input_one;
    assign in_two = spi_control ? virtual_input_two : phys_input_two;

    always_comb begin
        if (half_bridge_mode) begin
            want_a_hi = in_one;
            want_a_lo = !in_one;
            want_b_hi = in_two;
            want_b_lo = !in_two;
        end else begin
            // direction on one, pwm on two; pwm low recirculates through low sides
            want_a_hi = in_two && in_one;
            want_a_lo = !(in_two && in_one);
            want_b_hi = in_two && !in_one;
            want_b_lo = !(in_two && !in_one);
        end
    end

    // short faults latch in fault_flags until cleared
    assign short_a = fault_flags.short_ground_a || fault_flags.short_supply_a;
    assign short_b = fault_flags.short_ground_b || fault_flags.short_supply_b;

    // priority: the disabling pins and undervoltage beat all; crossed or double shorts take both legs
    always_comb begin
        brake_hs = 1'b0;
        if (!active_gate_input || shutoff_input) begin
            kill_a = 1'b1;
            kill_b = 1'b1;
        end else if (fault_live.supply_low_fault) begin
            kill_a = 1'b1;
            kill_b = 1'b1;
        end else if (software_output_gate) begin
            kill_a = 1'b1;
            kill_b = 1'b1;
        end else if (half_bridge_mode) begin
            kill_a = fault_flags.overheat_fault || short_a || (short_a && short_b);
            kill_b = fault_flags.overheat_fault || short_b || (short_a && short_b);
        end else if (fault_flags.short_ground_a || fault_flags.short_ground_b || fault_flags.overheat_fault) begin
            kill_a = 1'b1;
            kill_b = 1'b1;
        end else if (fault_live.supply_high_fault) begin
            // overvoltage brakes on the high sides and outranks supply shorts and current limit
            kill_a = 1'b0;
            kill_b = 1'b0;
            brake_hs = 1'b1;
        end else if (short_a || short_b) begin
            kill_a = 1'b1;
            kill_b = 1'b1;
        end else begin
            kill_a = 1'b0;
            kill_b = 1'b0;
            brake_hs = cl_r == hbridge_pkg::CL_DECAY || cl_r == hbridge_pkg::CL_HOLD;
        end
    end

    assign both_low = ol_r != hbridge_pkg::OL_IDLE;

    always_comb begin
        a_hi = 1'b0;
        a_lo = 1'b0;
        b_hi = 1'b0;
        b_lo = 1'b0;
        if (both_low) begin
            a_lo = ol_r == hbridge_pkg::OL_DISCHARGE && !kill_a;
            b_lo = !kill_b;
        end else if (standby) begin
            a_lo = 1'b0;
        end else if (brake_hs) begin
            a_hi = !kill_a;
            b_hi = !kill_b;
        end else begin
            // blanking stops turn-on of a leg that was off
            a_hi = want_a_hi && !kill_a && !(cl_r == hbridge_pkg::CL_BLANK && !prev_a_r);
            a_lo = want_a_lo && !kill_a;
            b_hi = want_b_hi && !kill_b && !(cl_r == hbridge_pkg::CL_BLANK && !prev_b_r);
            b_lo = want_b_lo && !kill_b;
        end
    end

    leg_drive #(.DEAD_CYC(2)) u_leg_a (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .drive_high(a_hi),
        .drive_low(a_lo),
        .gate(gate_a)
    );

    leg_drive #(.DEAD_CYC(2)) u_leg_b (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .drive_high(b_hi),
        .drive_low(b_lo),
        .gate(gate_b)
    );

    assign pullup_a_on = ol_r == hbridge_pkg::OL_PULLUP;

    // edge rate and limit level
    always_ff @(posedge ref_clk) begin
        if (!nrst) edge_rate_select <= hbridge_pkg::EDGE_RATE_RESET;
        else if (edge_rate_wr) edge_rate_select <= edge_rate_wr_data;
    end
    assign slew_bypass = edge_rate_select == hbridge_pkg::EDGE_RATE_BYPASS;
    assign limit_level = current_threshold;

    // serial output gated by the io supply level
    always_ff @(posedge ref_clk) begin
        if (!nrst) spi_word_out <= hbridge_pkg::SPI_ZERO_WORD;
        else spi_word_out <= io_supply_pin ? spi_word_in : hbridge_pkg::SPI_ZERO_WORD;
    end

    // fault latches: set beats clear; overvoltage/undervoltage track the condition
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            fault_flags <= '0;
        end else begin
            fault_flags <= (fault_clear ? '0 : fault_flags) | fault_live;
            fault_flags.supply_high_fault <= fault_live.supply_high_fault;
            fault_flags.supply_low_fault <= fault_live.supply_low_fault;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            prev_a_r <= 1'b0;
            prev_b_r <= 1'b0;
        end else begin
            prev_a_r <= want_a_hi;
            prev_b_r <= want_b_hi;
        end
    end
    assign in_off_edge = (prev_a_r && !want_a_hi) || (prev_b_r && !want_b_hi);

    // current limit: blank, then recirculate for twice the measured decay
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cl_r <= hbridge_pkg::CL_IDLE;
            cl_cnt_r <= '0;
            decay_r <= '0;
            overcurrent_flag <= 1'b0;
        end else begin
            if (over_limit && !half_bridge_mode && !standby) overcurrent_flag <= 1'b1;
            else if (fault_clear) overcurrent_flag <= 1'b0;
            if (half_bridge_mode || kill_a || kill_b || in_off_edge) begin
                cl_r <= hbridge_pkg::CL_IDLE;
            end else begin
                case (cl_r)
                    hbridge_pkg::CL_IDLE: if (over_limit && !standby) begin
                        cl_r <= hbridge_pkg::CL_BLANK;
                        // length fixed at start of interval
                        cl_cnt_r <= die_warm ? hbridge_pkg::CNT_W'(BLANK_WARM_CYC - 1)
                            : hbridge_pkg::CNT_W'(BLANK_CYC - 1);
                    end
                    hbridge_pkg::CL_BLANK: if (cl_cnt_r == '0) begin
                        cl_r <= hbridge_pkg::CL_DECAY;
                        decay_r <= '0;
                    end else cl_cnt_r <= cl_cnt_r - 1'b1;
                    // a decay longer than half the counter range wraps the doubled hold; widen CNT_W then
                    hbridge_pkg::CL_DECAY: if (!over_limit) begin
                        cl_r <= hbridge_pkg::CL_HOLD;
                        cl_cnt_r <= {decay_r[hbridge_pkg::CNT_W-2:0], 1'b1};
                    end else decay_r <= decay_r + 1'b1;
                    hbridge_pkg::CL_HOLD: if (cl_cnt_r == '0) cl_r <= hbridge_pkg::CL_IDLE;
                        else cl_cnt_r <= cl_cnt_r - 1'b1;
                    default: cl_r <= hbridge_pkg::CL_IDLE;
                endcase
            end
        end
    end

    // standby open-load test
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            standby_r <= 1'b1;
            check_r <= 1'b0;
        end else begin
            standby_r <= standby;
            check_r <= load_check_request;
        end
    end
    assign ol_start = !half_bridge_mode && load_check_request &&
        ((standby_r && !standby) || (standby && !check_r));

    // the low-side-off window of the active check
    assign ls_off = (!gate_a.ls && gate_b.ls) || (!gate_b.ls && gate_a.ls);

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ol_r <= hbridge_pkg::OL_IDLE;
            ol_cnt_r <= '0;
            open_load_flag <= 1'b0;
            ls_off_win_r <= 1'b0;
            seen_r <= 1'b0;
        end else begin
            // one cycle late copy marks the edge at which a low side comes back
            ls_off_win_r <= ls_off;
            case (ol_r)
                hbridge_pkg::OL_IDLE: if (ol_start) begin
                    ol_r <= hbridge_pkg::OL_DISCHARGE;
                    ol_cnt_r <= hbridge_pkg::CNT_W'(OL_STAGE_CYC - 1);
                end
                hbridge_pkg::OL_DISCHARGE: if (ol_cnt_r == '0) begin
                    ol_r <= hbridge_pkg::OL_PULLUP;
                    ol_cnt_r <= hbridge_pkg::CNT_W'(OL_STAGE_CYC - 1);
                end else ol_cnt_r <= ol_cnt_r - 1'b1;
                hbridge_pkg::OL_PULLUP: if (ol_cnt_r == '0) begin
                    ol_r <= hbridge_pkg::OL_IDLE;
                end else ol_cnt_r <= ol_cnt_r - 1'b1;
                default: ol_r <= hbridge_pkg::OL_IDLE;
            endcase
            if (ls_off && !half_bridge_mode && !standby) seen_r <= seen_r || overshoot_seen;
            else if (!ls_off) seen_r <= 1'b0;
            if (ol_r == hbridge_pkg::OL_PULLUP && ol_cnt_r == '0 && out_a_above_ol) begin
                open_load_flag <= 1'b1;
            end else if (ls_off_win_r && !ls_off && !half_bridge_mode && !standby) begin
                // window closing decides; no toggling, no window, flag untouched
                open_load_flag <= !(seen_r || overshoot_seen);
            end else if (fault_clear && !standby_r) begin
                open_load_flag <= 1'b0;
            end else if (half_bridge_mode || (standby && !standby_r)) begin
                open_load_flag <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> hbridge_ctrl_monitor.sv
// port checker for hbridge_ctrl, attached by bind
// assumes one ref_clk domain and a synchronous active-low nrst
`timescale 1ns/1ps
`default_nettype none
module hbridge_ctrl_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // inputs
    input wire logic half_bridge_mode,
    input wire logic standby,
    input wire logic software_output_gate,
    input wire logic active_gate_input,
    input wire logic shutoff_input,
    input wire logic io_supply_pin,
    input wire logic [15:0] spi_word_in,
    input wire logic [2:0] edge_rate_wr_data,
    input wire logic edge_rate_wr,
    input wire logic [1:0] current_threshold,
    input wire logic over_limit,
    // outputs
    input wire hbridge_pkg::leg_drive_t gate_a,
    input wire hbridge_pkg::leg_drive_t gate_b,
    input wire logic pullup_a_on,
    input wire logic [2:0] edge_rate_select,
    input wire logic slew_bypass,
    input wire logic [1:0] limit_level,
    input wire logic [15:0] spi_word_out,
    input wire logic overcurrent_flag,
    input wire logic open_load_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    leg_a_shoot_a: assert property (!(gate_a.hs && gate_a.ls)) else $error("leg a both gates on");
    leg_b_shoot_a: assert property (!(gate_b.hs && gate_b.ls)) else $error("leg b both gates on");
    dead_time_a: assert property ($fell(gate_a.ls) |-> !gate_a.hs ##1 !gate_a.hs)
        else $error("leg a high side without dead time");
    spi_zero_a: assert property (!io_supply_pin |=> spi_word_out == 16'h0000)
        else $error("serial word not zero without io supply");
    spi_pass_a: assert property (io_supply_pin |=> spi_word_out == $past(spi_word_in))
        else $error("serial word not passed through");
    rate_write_a: assert property (edge_rate_wr |=> edge_rate_select == $past(edge_rate_wr_data))
        else $error("edge rate write lost");
    bypass_code_a: assert property (slew_bypass == (edge_rate_select == 3'h0)) else $error("bypass mismatch");
    limit_step_a: assert property (limit_level == current_threshold) else $error("limit step mismatch");
    oc_flag_a: assert property (over_limit && !half_bridge_mode && !standby && active_gate_input
        && !shutoff_input |=> overcurrent_flag) else $error("overcurrent not flagged");
    kill_off_a: assert property ((shutoff_input || !active_gate_input || software_output_gate) [*2]
        |-> {gate_a, gate_b} == 4'h0) else $error("outputs on while disabled");
    half_no_ol_a: assert property (half_bridge_mode [*2] |-> !open_load_flag)
        else $error("open load in half-bridge");
    pullup_legs_a: assert property (pullup_a_on [*2] |-> gate_b.ls && !gate_a.ls)
        else $error("pull-up stage gate mismatch");
endmodule
bind hbridge_ctrl hbridge_ctrl_monitor hbridge_ctrl_monitor_i (.ref_clk, .nrst, .half_bridge_mode, .standby,
    .software_output_gate, .active_gate_input, .shutoff_input, .io_supply_pin, .spi_word_in, .edge_rate_wr_data,
    .edge_rate_wr, .current_threshold, .over_limit, .gate_a, .gate_b, .pullup_a_on, .edge_rate_select,
    .slew_bypass, .limit_level, .spi_word_out, .overcurrent_flag, .open_load_flag);
`default_nettype wire

// >>> host_model.sv
// host side: io supply pin and the word queued for the serial output
// assumes the bench decides when the io supply is present
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock
    input wire logic ref_clk,
    // control from the bench
    input wire logic io_en,
    // pins toward the device
    output logic io_supply_pin,
    output logic [15:0] spi_word_in
);
    int seed = 32'h1A25;
    // pin has a pull-down: an absent supply reads low, a fresh word every cycle
    always @(negedge ref_clk) begin
        io_supply_pin <= io_en;
        spi_word_in <= 16'($random(seed));
    end
endmodule
`default_nettype wire

// >>> hbridge_ctrl_tb_top.sv
// self-checking bench for hbridge_ctrl with shortened blanking and test stages
// assumes the host model supplies the serial word and io supply pin
`timescale 1ns/1ps
`default_nettype none
module hbridge_ctrl_tb_top;
    localparam int BL = 8;
    localparam int BW = 64;
    localparam int OS = 16;
    logic ref_clk = 1'b0, nrst = 1'b0, half_bridge_mode = 1'b0, spi_control = 1'b0, io_en = 1'b0;
    logic virtual_input_one = 1'b0, virtual_input_two = 1'b0, software_output_gate = 1'b0, standby = 1'b0;
    logic load_check_request = 1'b0, edge_rate_wr = 1'b0, fault_clear = 1'b0, phys_input_one = 1'b0;
    logic phys_input_two = 1'b0, active_gate_input = 1'b1, shutoff_input = 1'b0, over_limit = 1'b0;
    logic die_warm = 1'b0, overshoot_seen = 1'b0, out_a_above_ol = 1'b0;
    logic [1:0] current_threshold = 2'h0;
    logic [2:0] edge_rate_wr_data = 3'h0;
    hbridge_pkg::fault_set_t fault_live = '0;
    hbridge_pkg::leg_drive_t gate_a, gate_b;
    hbridge_pkg::fault_set_t fault_flags;
    logic io_supply_pin, pullup_a_on, slew_bypass, overcurrent_flag, open_load_flag;
    logic [2:0] edge_rate_select;
    logic [1:0] limit_level;
    logic [15:0] spi_word_in, spi_word_out;
    logic [15:0] exp_q[$];
    int checks = 0;
    int miscompares = 0;

    always #12.5 ref_clk = ~ref_clk;

    host_model host_model_i (.ref_clk, .io_en, .io_supply_pin, .spi_word_in);
    hbridge_ctrl #(.BLANK_CYC(BL), .BLANK_WARM_CYC(BW), .OL_STAGE_CYC(OS)) hbridge_ctrl_i (.ref_clk, .nrst,
        .half_bridge_mode, .spi_control, .virtual_input_one, .virtual_input_two, .software_output_gate,
        .load_check_request, .current_threshold, .edge_rate_wr_data, .edge_rate_wr, .fault_clear, .standby,
        .phys_input_one, .phys_input_two, .active_gate_input, .shutoff_input, .io_supply_pin, .spi_word_in,
        .over_limit, .die_warm, .fault_live, .overshoot_seen, .out_a_above_ol, .gate_a, .gate_b, .pullup_a_on,
        .edge_rate_select, .slew_bypass, .limit_level, .spi_word_out, .fault_flags, .overcurrent_flag,
        .open_load_flag);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // bounded wait so a stuck sequence still ends in a compare
    task automatic wait_gates(input logic [3:0] want);
        int n = 0;
        while ({gate_a, gate_b} !== want && n < 200) begin
            cyc(1);
            n++;
        end
        chk({gate_a, gate_b}, want);
    endtask

    task automatic close_out;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // noted serial word, compared one edge later against the registered output
    always @(posedge ref_clk) begin
        if (!nrst) begin
            exp_q.delete();
        end else begin
            if (exp_q.size() > 0) chk(spi_word_out, exp_q.pop_front());
            exp_q.push_back(io_supply_pin ? spi_word_in : 16'h0000);
        end
    end

    initial begin
        #(25 * 5000);
        miscompares++;
        close_out;
    end

    initial begin
        cyc(2);
        nrst = 1'b1;
        chk(edge_rate_select, 3'h4);
        chk({gate_a, gate_b}, 4'h0);
        cyc(20);
        io_en = 1'b1;
        for (int c = 0; c < 8; c++) begin
            edge_rate_wr_data = c[2:0];
            current_threshold = c[1:0];
            edge_rate_wr = 1'b1;
            cyc(1);
            edge_rate_wr = 1'b0;
            cyc(1);
            chk(edge_rate_select, c[2:0]);
            chk(slew_bypass, c == 0);
            chk(limit_level, c[1:0]);
        end
        // wrong source always drives the inverse, so a swapped select shows
        for (int m = 0; m < 16; m++) begin
            half_bridge_mode = !m[3];
            spi_control = m[2];
            {phys_input_one, phys_input_two} = m[2] ? ~m[1:0] : m[1:0];
            {virtual_input_one, virtual_input_two} = m[2] ? m[1:0] : ~m[1:0];
            cyc(8);
            if (!m[3]) chk({gate_a, gate_b}, {m[1], !m[1], m[0], !m[0]});
            else chk({gate_a, gate_b}, m[0] ? (m[1] ? 4'h9 : 4'h6) : 4'h5);
        end
        for (int k = 0; k < 4; k++) begin
            shutoff_input = (k == 0);
            active_gate_input = (k != 1);
            software_output_gate = (k == 2);
            fault_live.supply_low_fault = (k == 3);
            cyc(3);
            chk({gate_a, gate_b}, 4'h0);
            {shutoff_input, active_gate_input, software_output_gate, fault_live.supply_low_fault} = 4'h4;
            cyc(8);
            chk({gate_a, gate_b}, 4'h9);
        end
        // warm level flips mid-blank: the running interval keeps its length
        for (int w = 0; w < 2; w++) begin
            die_warm = w[0];
            over_limit = 1'b1;
            cyc(1);
            die_warm = !w[0];
            cyc(1);
            chk(overcurrent_flag, 1'b1);
            cyc(BL + 8);
            chk({gate_a, gate_b}, w[0] ? 4'h9 : 4'hA);
            cyc(BW);
            chk({gate_a, gate_b}, 4'hA);
            over_limit = 1'b0;
            die_warm = 1'b0;
            wait_gates(4'h9);
            fault_clear = 1'b1;
            cyc(1);
            fault_clear = 1'b0;
            cyc(1);
            chk(overcurrent_flag, 1'b0);
        end
        // a one-cycle short latches: whole bridge in h-bridge mode, one leg in half-bridge mode
        for (int h = 0; h < 2; h++) begin
            half_bridge_mode = h[0];
            fault_live.short_ground_a = 1'b1;
            cyc(1);
            fault_live.short_ground_a = 1'b0;
            cyc(8);
            chk(fault_flags, 7'h20);
            chk({gate_a, gate_b}, h[0] ? 4'h2 : 4'h0);
            fault_clear = 1'b1;
            cyc(1);
            fault_clear = 1'b0;
            cyc(8);
            chk(fault_flags, 7'h00);
            chk({gate_a, gate_b}, h[0] ? 4'hA : 4'h9);
        end
        half_bridge_mode = 1'b0;
        standby = 1'b1;
        cyc(6);
        chk({gate_a, gate_b}, 4'h0);
        load_check_request = 1'b1;
        wait_gates(4'h5);
        wait_gates(4'h1);
        chk(pullup_a_on, 1'b1);
        out_a_above_ol = 1'b1;
        wait_gates(4'h0);
        chk(open_load_flag, 1'b1);
        // back to normal with pwm on input two; each closing window decides the flag
        standby = 1'b0;
        load_check_request = 1'b0;
        virtual_input_two = 1'b0;
        cyc(4);
        for (int p = 0; p < 3; p++) begin
            overshoot_seen = !p[0];
            virtual_input_two = 1'b1;
            cyc(10);
            virtual_input_two = 1'b0;
            cyc(10);
            chk(open_load_flag, p[0]);
        end
        // full duty: the window never closes, the flag keeps its value
        overshoot_seen = 1'b0;
        virtual_input_two = 1'b1;
        cyc(20);
        chk(open_load_flag, 1'b0);
        close_out;
    end
endmodule
`default_nettype wire
